/* lcbd_pkg.sv */
// Constants, register map and field layout for the LED charge bar display.
// Assumes a 40 MHz system clock and an AXI4-Lite master with 32-bit data.
package lcbd_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int CLOCK_HZ           = 40_000_000;
   localparam int DISPLAY_TIME_S     = 4;
   localparam int DISPLAY_CYCLES_DEF = DISPLAY_TIME_S * CLOCK_HZ;
   localparam int BLINK_HALF_MS      = 500;
   localparam int BLINK_HALF_DEF     = (CLOCK_HZ / 1000) * BLINK_HALF_MS;
   localparam int COUNT_W            = 28;
   localparam int BLINK_W            = 25;

   ////////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses.
   localparam int         ADDR_W          = 8;
   localparam logic [7:0] CONFIG_OFFSET   = 8'h00;
   localparam logic [7:0] CHARGE_OFFSET   = 8'h04;
   localparam logic [7:0] CAPACITY_OFFSET = 8'h08;
   localparam logic [7:0] STATUS_OFFSET   = 8'h0c;

   // Configuration fields.
   localparam int CFG_COUNT_LSB = 0;
   localparam int CFG_REF_BIT   = 2;
   localparam int CFG_EOD_BIT   = 3;
   localparam int CFG_W         = 4;

   // Charge fields: relative level in bits 6:0, absolute level in bits 14:8.
   localparam int CHG_REL_LSB = 0;
   localparam int CHG_ABS_LSB = 8;
   localparam int SOC_W       = 7;

   // Capacity fields: remaining in 15:0, alarm level in 31:16.
   localparam int CAP_REM_LSB   = 0;
   localparam int CAP_ALARM_LSB = 16;
   localparam int CAP_W         = 16;

   // Status fields.
   localparam int STS_ON_BIT    = 8;
   localparam int STS_ALARM_BIT = 9;
   localparam int STS_PHASE_BIT = 10;

   // Reset values.
   localparam logic [CFG_W-1:0] CONFIG_RESET   = 4'h0;
   localparam logic [31:0]      CHARGE_RESET   = 32'h0000_0000;
   localparam logic [31:0]      CAPACITY_RESET = 32'h0000_0000;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // Segment count selection and lighting thresholds in percent.
   typedef enum logic [1:0] {
      SEG_FIVE  = 2'b00,
      SEG_FOUR  = 2'b01,
      SEG_THREE = 2'b10
   } lcbd_seg_count_type;

   localparam logic [6:0] FIVE_T2  = 7'h14;
   localparam logic [6:0] FIVE_T3  = 7'h28;
   localparam logic [6:0] FIVE_T4  = 7'h3c;
   localparam logic [6:0] FIVE_T5  = 7'h50;
   localparam logic [6:0] FOUR_T2  = 7'h19;
   localparam logic [6:0] FOUR_T3  = 7'h32;
   localparam logic [6:0] FOUR_T4  = 7'h4b;
   localparam logic [6:0] THREE_T2 = 7'h22;
   localparam logic [6:0] THREE_T3 = 7'h43;
   localparam int         LED_W    = 5;

endpackage : lcbd_pkg

/* lcbd_display.sv */
// LED charge bar display: request edge detector, display timer, blinker,
// segment decoder and an AXI4-Lite register slave.
// Assumes the request input and all bus inputs are synchronous to clock.
//
// What this block does
// - Drives three, four or five segments, count picked by configuration bits.
// - Reference select picks full charge capacity or design capacity as full scale.
// - Falling edge of the active-low request turns display on for four seconds.
// - Further falling edges are ignored until the running display timer expires.
// - End-of-discharge flag forces every segment off regardless of anything else.
// - Segments step by 20, 25 or 33 percent of relative or absolute charge.
// - Lit segments blink while remaining capacity is below the alarm level.
// - Five segments: first always lit, others at 20, 40, 60, 80 percent.
// - Four segments: first always lit, others at 25, 50, 75 percent.
// - Three segments: first always lit, others at 34 and 67 percent.
`timescale 1ns/1ps

module lcbd_display
   import lcbd_pkg::*;
#(
   parameter int DISPLAY_CYCLES = DISPLAY_CYCLES_DEF,
   parameter int BLINK_HALF     = BLINK_HALF_DEF
) (
   input  wire logic              clock,
   input  wire logic              rstn,
   input  wire logic              display_request_n,
   output logic [LED_W-1:0]       led_segment,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);

   // Refuse counts that do not fit the counters.
   if (DISPLAY_CYCLES < 2 || DISPLAY_CYCLES >= (1 << COUNT_W)) begin : g_bad_display
      $error("DISPLAY_CYCLES out of range");
   end
   if (BLINK_HALF < 1 || BLINK_HALF >= (1 << BLINK_W)) begin : g_bad_blink
      $error("BLINK_HALF out of range");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Functions.

   // Merges write data into a register under the byte strobes.
   function automatic logic [31:0] merge_strobe(input logic [31:0] old_value,
                                                input logic [31:0] data,
                                                input logic [3:0]  strb);
      logic [31:0] result;
      result = old_value;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            result[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return result;
   endfunction : merge_strobe

   // True when a byte address hits a mapped register.
   function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
      return (addr == CONFIG_OFFSET) || (addr == CHARGE_OFFSET) ||
             (addr == CAPACITY_OFFSET) || (addr == STATUS_OFFSET);
   endfunction : is_mapped

   // Converts a charge level into the bar pattern for the chosen segment count.
   function automatic logic [LED_W-1:0] seg_mask(input lcbd_seg_count_type count,
                                                 input logic [SOC_W-1:0] soc);
      logic [LED_W-1:0] mask;
      mask = '0;
      unique case (count)
         SEG_FOUR: begin
            mask = {1'b0, soc >= FOUR_T4, soc >= FOUR_T3, soc >= FOUR_T2, 1'b1};
         end
         SEG_THREE: begin
            mask = {2'b00, soc >= THREE_T3, soc >= THREE_T2, 1'b1};
         end
         default: begin
            // Five segments; the unused code also falls back here.
            mask = {soc >= FIVE_T5, soc >= FIVE_T4, soc >= FIVE_T3, soc >= FIVE_T2,
                    1'b1};
         end
      endcase
      return mask;
   endfunction : seg_mask

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and derived controls.
   logic [CFG_W-1:0]   config_reg;
   logic [31:0]        charge_reg;
   logic [31:0]        capacity_reg;
   lcbd_seg_count_type seg_count;
   logic               ref_absolute;
   logic               end_of_discharge_flag;
   logic [SOC_W-1:0]   relative_level;
   logic [SOC_W-1:0]   absolute_level;
   logic [SOC_W-1:0]   shown_level;
   logic [CAP_W-1:0]   remaining_capacity_value;
   logic [CAP_W-1:0]   alarm_level;
   logic               capacity_alarm;

   // Field extraction from the software-written registers.
   assign seg_count                = lcbd_seg_count_type'(config_reg[CFG_COUNT_LSB +: 2]);
   assign ref_absolute             = config_reg[CFG_REF_BIT];
   assign end_of_discharge_flag    = config_reg[CFG_EOD_BIT];
   assign relative_level           = charge_reg[CHG_REL_LSB +: SOC_W];
   assign absolute_level           = charge_reg[CHG_ABS_LSB +: SOC_W];
   assign remaining_capacity_value = capacity_reg[CAP_REM_LSB +: CAP_W];
   assign alarm_level              = capacity_reg[CAP_ALARM_LSB +: CAP_W];

   // Absolute mode shows charge against design capacity, relative against full charge.
   assign shown_level    = ref_absolute ? absolute_level : relative_level;
   assign capacity_alarm = remaining_capacity_value < alarm_level;

   ////////////////////////////////////////////////////////////////////////////////
   // Request edge detector and display timer.
   logic               request_prev;
   logic               request_fall;
   logic [COUNT_W-1:0] display_count;
   logic               display_on;

   // Remembers the request level so a fall can be seen; released button is high.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         request_prev <= 1'b1;
      end else begin
         request_prev <= display_request_n;
      end
   end

   assign request_fall = request_prev && !display_request_n;
   assign display_on   = display_count != '0;

   // Loads four seconds on a fall while idle, then counts down to expiry.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         display_count <= '0;
      end else if (request_fall && !display_on) begin
         display_count <= COUNT_W'(DISPLAY_CYCLES);
      end else if (display_on) begin
         display_count <= display_count - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Blink phase generator; restarts lit at every activation.
   logic [BLINK_W-1:0] blink_count;
   logic               blink_phase;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         blink_count <= '0;
         blink_phase <= 1'b1;
      end else if (!display_on || !capacity_alarm) begin
         blink_count <= '0;
         blink_phase <= 1'b1;
      end else if (blink_count == BLINK_W'(BLINK_HALF - 1)) begin
         blink_count <= '0;
         blink_phase <= !blink_phase;
      end else begin
         blink_count <= blink_count + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Segment outputs, registered.
   logic [LED_W-1:0] next_led;

   // Dark when idle, at end of discharge, or in the dark half of a blink.
   always_comb begin
      next_led = '0;
      if (display_on && !end_of_discharge_flag && (!capacity_alarm || blink_phase)) begin
         next_led = seg_mask(seg_count, shown_level);
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         led_segment <= '0;
      end else begin
         led_segment <= next_led;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel: address and data taken in either order.
   logic              aw_held;
   logic              w_held;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              do_write;

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign do_write      = aw_held && w_held && !s_axi_bvalid;

   // Captures address and data, then raises the response once both are in.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= '0;
         w_data       <= '0;
         w_strb       <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Register updates; the status word is read only and ignores writes.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         config_reg   <= CONFIG_RESET;
         charge_reg   <= CHARGE_RESET;
         capacity_reg <= CAPACITY_RESET;
      end else if (do_write) begin
         if (aw_addr == CONFIG_OFFSET) begin
            config_reg <= CFG_W'(merge_strobe({28'h0, config_reg}, w_data, w_strb));
         end
         if (aw_addr == CHARGE_OFFSET) begin
            charge_reg <= merge_strobe(charge_reg, w_data, w_strb);
         end
         if (aw_addr == CAPACITY_OFFSET) begin
            capacity_reg <= merge_strobe(capacity_reg, w_data, w_strb);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel: one cycle from address to data.
   logic [31:0] next_rdata;

   assign s_axi_arready = !s_axi_rvalid;

   // Selects the read word; unmapped addresses read zero.
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
         CONFIG_OFFSET:   next_rdata = {28'h0, config_reg};
         CHARGE_OFFSET:   next_rdata = charge_reg & 32'h0000_7f7f;
         CAPACITY_OFFSET: next_rdata = capacity_reg;
         STATUS_OFFSET: begin
            next_rdata[LED_W-1:0]    = led_segment;
            next_rdata[STS_ON_BIT]    = display_on;
            next_rdata[STS_ALARM_BIT] = capacity_alarm;
            next_rdata[STS_PHASE_BIT] = blink_phase;
         end
         default:         next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   timer_start_a: assert property (@(posedge clock) disable iff (!rstn)
      request_fall && !display_on |=> display_count == COUNT_W'(DISPLAY_CYCLES))
      else $error("display timer did not load on request fall");

   edge_ignored_a: assert property (@(posedge clock) disable iff (!rstn)
      request_fall && display_on |=> display_count == $past(display_count) - 1'b1)
      else $error("request fall restarted a running timer");

   eod_blank_a: assert property (@(posedge clock) disable iff (!rstn)
      end_of_discharge_flag |=> led_segment == '0)
      else $error("segments lit during end of discharge");

   idle_dark_a: assert property (@(posedge clock) disable iff (!rstn)
      !display_on |=> led_segment == '0)
      else $error("segments lit while display timer idle");

   first_lit_a: assert property (@(posedge clock) disable iff (!rstn)
      display_on && !end_of_discharge_flag && !capacity_alarm |=> led_segment[0])
      else $error("first segment dark while display on");

   five_full_a: assert property (@(posedge clock) disable iff (!rstn)
      display_on && !end_of_discharge_flag && !capacity_alarm &&
      seg_count == SEG_FIVE && shown_level >= FIVE_T5 |=> led_segment == 5'h1f)
      else $error("five segment full bar wrong");

   three_mid_a: assert property (@(posedge clock) disable iff (!rstn)
      display_on && !end_of_discharge_flag && !capacity_alarm &&
      seg_count == SEG_THREE && shown_level >= THREE_T2 && shown_level < THREE_T3
      |=> led_segment == 5'h03)
      else $error("three segment middle bar wrong");

   blink_dark_a: assert property (@(posedge clock) disable iff (!rstn)
      display_on && capacity_alarm && !blink_phase |=> led_segment == '0)
      else $error("segments lit in dark blink phase");

   blink_hold_a: assert property (@(posedge clock) disable iff (!rstn)
      display_on && capacity_alarm && blink_count != BLINK_W'(BLINK_HALF - 1)
      |=> blink_phase == $past(blink_phase))
      else $error("blink phase changed early");

   write_resp_a: assert property (@(posedge clock) disable iff (!rstn)
      do_write |=> s_axi_bvalid && !aw_held && !w_held)
      else $error("write response missing");

   read_resp_a: assert property (@(posedge clock) disable iff (!rstn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");

endmodule : lcbd_display

/* lcbd_partner.sv */
// Partner model: pushbutton with a pull-up on the request line, plus a bar observer.
// Assumes the bench drives press from the same clock as the display block.
`timescale 1ns/1ps

module lcbd_partner
   import lcbd_pkg::*;
(
   input  wire logic             clock,
   input  wire logic             rstn,
   input  wire logic             press,
   input  wire logic [LED_W-1:0] led_segment,
   output logic                  display_request_n,
   output logic                  any_lit
);
   ////////////////////////////////////////////////////////////////////////////////
   // The pull-up holds the line high whenever the switch is open.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         display_request_n <= 1'b1;
      end else begin
         display_request_n <= !press;
      end
   end

   // Any lit segment means the bar is visible.
   assign any_lit = |led_segment;
endmodule : lcbd_partner

/* lcbd_display_test.sv */
// Self-checking bench for the LED charge bar display.
// Assumes short display and blink counts so the whole run stays brief.
`timescale 1ns/1ps

module lcbd_display_test
   import lcbd_pkg::*;
;
   localparam int N_DISPLAY_REQUEST_N = 20;
   logic        clock = 0, rstn = 0, press = 0, probe = 0;
   logic        any_lit, req_n;
   logic [4:0]  led;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, seed = 32'hd01c;
   logic [3:0]  wstrb = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [33:0] rd_q[$];
   logic [1:0]  wr_q[$];
   logic [4:0]  led_q[$];
   int          n_mismatch = 0, checked = 0, cycles = 0, n_on, n_off, r, a, ref_abs, m;
   int          lv[20] = '{0, 19, 20, 39, 40, 59, 60, 79, 80, 24, 25, 49, 50, 74, 75,
                           33, 34, 66, 67, 100};

   always #12.5 clock = ~clock;

   lcbd_display #(.DISPLAY_CYCLES(N_DISPLAY_REQUEST_N), .BLINK_HALF(3)) lcbd_display_i (
      .clock(clock), .rstn(rstn), .display_request_n(req_n), .led_segment(led),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   lcbd_partner lcbd_partner_i (.clock(clock), .rstn(rstn), .press(press),
      .led_segment(led), .display_request_n(req_n), .any_lit(any_lit));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   // Bar pattern for a segment count code and a charge level in percent.
   function automatic logic [4:0] exp_pat(input int mode, input int l);
      int n;
      if (mode == 1) n = 1 + (l >= 25) + (l >= 50) + (l >= 75);
      else if (mode == 2) n = 1 + (l >= 34) + (l >= 67);
      else n = 1 + (l >= 20) + (l >= 40) + (l >= 60) + (l >= 80);
      return 5'((1 << n) - 1);
   endfunction : exp_pat

   ////////////////////////////////////////////////////////////////////////////////
   // Watcher: takes the oldest note whenever a response or a probe appears.
   always @(posedge clock) begin
      cycles++;
      if (bvalid === 1'b1 && bready) check("bresp", 34'(bresp), 34'(wr_q.pop_front()));
      if (rvalid === 1'b1 && rready) check("read", {rresp, rdata}, rd_q.pop_front());
      if (probe) begin
         // The partner's visibility flag must agree with the expected bar.
         check("lit", 34'(any_lit), 34'(|led_q[0]));
         check("led", 34'(led), 34'(led_q.pop_front()));
      end
      if (cycles > 20000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end

   task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] e);
      @(posedge clock);
      wr_q.push_back(e);
      awaddr <= ad;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clock);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] ad, input logic [33:0] e);
      @(posedge clock);
      rd_q.push_back(e);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clock);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
   endtask : rd

   task automatic probe_led(input logic [4:0] e);
      led_q.push_back(e);
      probe <= 1'b1;
      @(posedge clock);
      probe <= 1'b0;
      @(posedge clock);
   endtask : probe_led

   task automatic push(input int hold);
      @(posedge clock);
      press <= 1'b1;
      repeat (hold) @(posedge clock);
      press <= 1'b0;
      repeat (2) @(posedge clock);
   endtask : push

   // One activation: program, press, look at the bar, then look after expiry.
   task automatic show(input logic [3:0] cfg, input int rl, input int ab, input logic [4:0] e);
      wr(CONFIG_OFFSET, 32'(cfg), 4'hf, RESP_OKAY);
      wr(CHARGE_OFFSET, {17'h0, 7'(ab), 1'b0, 7'(rl)}, 4'hf, RESP_OKAY);
      push(3);
      probe_led(e);
      repeat (N_DISPLAY_REQUEST_N + 4) @(posedge clock);
      probe_led(5'h00);
   endtask : show

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence: registers, bar tables, reference, blanking, blink, retrigger.
   initial begin
      repeat (4) @(posedge clock);
      rstn <= 1'b1;
      rd(CONFIG_OFFSET, {RESP_OKAY, 32'h0});
      rd(CHARGE_OFFSET, {RESP_OKAY, 32'h0});
      rd(CAPACITY_OFFSET, {RESP_OKAY, 32'h0});
      wr(8'h10, 32'h1, 4'hf, RESP_SLVERR);
      rd(8'h10, {RESP_SLVERR, 32'h0});
      wr(STATUS_OFFSET, 32'hffff_ffff, 4'hf, RESP_OKAY);
      rd(STATUS_OFFSET, {RESP_OKAY, 32'(1) << STS_PHASE_BIT});
      wr(CHARGE_OFFSET, 32'hffff_ffff, 4'hf, RESP_OKAY);
      rd(CHARGE_OFFSET, {RESP_OKAY, 32'h0000_7f7f});
      wr(CONFIG_OFFSET, 32'hffff_ffff, 4'h1, RESP_OKAY);
      wr(CONFIG_OFFSET, 32'h0, 4'he, RESP_OKAY);
      rd(CONFIG_OFFSET, {RESP_OKAY, 32'hf});
      wr(CAPACITY_OFFSET, 32'h1234_5678, 4'hf, RESP_OKAY);
      rd(CAPACITY_OFFSET, {RESP_OKAY, 32'h1234_5678});
      wr(CAPACITY_OFFSET, 32'h0, 4'hf, RESP_OKAY);
      for (int k = 0; k < 80; k++) show(4'(k / 20), lv[k % 20], 0, exp_pat(k / 20, lv[k % 20]));
      show(4'h4, 10, 90, 5'h1f);
      show(4'h0, 10, 90, 5'h01);
      show(4'h8, 100, 100, 5'h00);
      for (int k = 0; k < 8; k++) begin
         seed = xs(seed);
         r = int'(seed[7:0]) % 101;
         a = int'(seed[15:8]) % 101;
         m = int'(seed[17:16]);
         ref_abs = int'(seed[18]);
         show(4'(m + 4 * ref_abs), r, a, exp_pat(m, ref_abs ? a : r));
      end
      wr(CAPACITY_OFFSET, {16'd10, 16'd5}, 4'hf, RESP_OKAY);
      wr(CONFIG_OFFSET, 32'h0, 4'hf, RESP_OKAY);
      wr(CHARGE_OFFSET, 32'd45, 4'hf, RESP_OKAY);
      push(3);
      n_on = 0;
      n_off = 0;
      repeat (6) begin
         @(posedge clock);
         n_on += (led === 5'h07);
         n_off += (led === 5'h00);
      end
      check("blink lit", 34'(n_on), 34'd3);
      check("blink dark", 34'(n_off), 34'd3);
      repeat (N_DISPLAY_REQUEST_N + 4) @(posedge clock);
      wr(CAPACITY_OFFSET, 32'h0, 4'hf, RESP_OKAY);
      wr(CHARGE_OFFSET, 32'd100, 4'hf, RESP_OKAY);
      push(2);
      repeat (6) @(posedge clock);
      press <= 1'b1;
      repeat (16) @(posedge clock);
      probe_led(5'h00);
      repeat (4) @(posedge clock);
      probe_led(5'h00);
      press <= 1'b0;
      repeat (3) @(posedge clock);
      show(4'h0, 100, 0, 5'h1f);
      tally_and_finish();
   end
endmodule : lcbd_display_test
